// *** core/pfb_defs.svh ***
`ifndef PFB_DEFS_SVH
`define PFB_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PFB_OFS_FLAGS_C 4'h0
`define PFB_OFS_FLAGS_D 4'h4
`define PFB_OFS_EN_C 4'h8
`define PFB_OFS_EN_D 4'hc

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PFB_POS_CAP4 5
`define PFB_POS_CAP3 4
`define PFB_POS_TMR6 3
`define PFB_POS_TMR4 1
`define PFB_POS_COLL 1
`define PFB_POS_DONE 0

// ----------------------------------------
// Implemented bits and reset values
// ----------------------------------------
`define PFB_MASK_C 8'h3a
`define PFB_MASK_D 8'h03
`define PFB_RST_FLAGS 8'h00
`define PFB_RST_EN 8'h00
`define PFB_RST_RDATA 32'h0000_0000

`endif

// *** core/pfb_pkg.sv ***
package pfb_pkg;

    // ----------------------------------------
    // Bus handshake states
    // ----------------------------------------
    typedef enum logic [1:0] {
        pfb_idle = 2'b01,
        pfb_ack = 2'b10
    } pfb_bus_st_t;

    // ----------------------------------------
    // State records
    // ----------------------------------------
    typedef struct packed {
        pfb_bus_st_t bus;
        logic waitreq;
        logic [31:0] rdata;
        logic [7:0] en_c;
        logic [7:0] en_d;
        logic irq;
    } pfb_top_st_t;

    typedef struct packed {
        logic [7:0] flags;
    } pfb_cell_st_t;

    typedef struct packed {
        logic eq;
        logic hit;
    } pfb_match_st_t;

endpackage

// *** core/pfb_flag_if.sv ***
`timescale 1ns/1ns
interface pfb_flag_if;
    logic [7:0] set;
    logic [7:0] wr_mask;
    logic [7:0] wr_data;
    logic [7:0] q;
    modport bank (input set, input wr_mask, input wr_data, output q);
    modport ctl (output set, output wr_mask, output wr_data, input q);
endinterface

// *** core/pfb_flag_cell.sv ***
`timescale 1ns/1ns
`include "pfb_defs.svh"
module pfb_flag_cell #(
    parameter logic [7:0] IMPL_MASK = 8'hff
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic srst_in,
    // Flag bank access
    pfb_flag_if.bank fl
);
    pfb_pkg::pfb_cell_st_t st_q;
    pfb_pkg::pfb_cell_st_t st_d;

    // ----------------------------------------
    // Sticky flags, hardware set beats write
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.flags = (st_q.flags & ~fl.wr_mask) | (fl.wr_data & fl.wr_mask);
        st_d.flags = (st_d.flags | fl.set) & IMPL_MASK;
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            st_q.flags <= `PFB_RST_FLAGS;
        end else begin
            st_q <= st_d;
        end
    end

    assign fl.q = st_q.flags;
endmodule

// *** core/pfb_match_det.sv ***
`timescale 1ns/1ns
module pfb_match_det #(
    parameter int TW = 8
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic srst_in,
    // Timer view
    input wire logic [TW-1:0] count_in,
    input wire logic [TW-1:0] period_in,
    // Match pulse
    output logic hit_out
);
    pfb_pkg::pfb_match_st_t st_q;
    pfb_pkg::pfb_match_st_t st_d;

    generate
        if (TW < 1 || TW > 16) begin : g_bad_tw
            $error("pfb_match_det: TW out of range");
        end
    endgenerate

    // ----------------------------------------
    // One pulse per new match, so a held match
    // does not refill a flag software cleared
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.eq = (count_in == period_in);
        st_d.hit = st_d.eq & ~st_q.eq;
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign hit_out = st_q.hit;
endmodule

// *** core/pfb_flags_bank.sv ***
// Function
// - Flags latch on event, whatever the enables
// - No enable or global gating on setting
// - Bank c bits: cap4 5, cap3 4, t6 3, t4 1
// - Timer flag sets when count equals period
// - Unused bits read zero, ignore writes
// - All flags clear on any reset
// - Bank d bit 1 set on collision
// - Bank d bit 0 set on serial completion
// - Serial flag zero while transfer pending
// - Bank d software writable, hardware set wins
`timescale 1ns/1ns
`include "pfb_defs.svh"
module pfb_flags_bank #(
    parameter int TW = 8
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic srst_in,
    // Avalon-MM slave
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Capture/compare events
    input wire logic cap_unit3_event_in,
    input wire logic cap_unit4_event_in,
    // Timers
    input wire logic [TW-1:0] timer_four_count_in,
    input wire logic [TW-1:0] timer_four_period_in,
    input wire logic [TW-1:0] timer_six_count_in,
    input wire logic [TW-1:0] timer_six_period_in,
    // Second serial port events
    input wire logic serial2_done_event_in,
    input wire logic serial2_collision_event_in,
    // Request and flag views
    output logic peripheral_irq_out,
    output logic [7:0] flags_c_out,
    output logic [7:0] flags_d_out
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic addr_is(input logic [3:0] addr, input logic [3:0] ofs);
        addr_is = (addr[3:2] == ofs[3:2]);
    endfunction

    pfb_pkg::pfb_top_st_t st_q;
    pfb_pkg::pfb_top_st_t st_d;

    pfb_flag_if fc ();
    pfb_flag_if fd ();

    logic t4_hit;
    logic t6_hit;
    logic wr_ack;
    logic [7:0] wbyte;
    logic [7:0] rd_mux;
    logic [7:0] pend;

    generate
        if (TW < 1 || TW > 16) begin : g_bad_tw
            $error("pfb_flags_bank: TW out of range");
        end
    endgenerate

    // ----------------------------------------
    // Timer period match detectors
    // ----------------------------------------
    pfb_match_det #(
        .TW(TW)
    ) u_t4 (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .count_in(timer_four_count_in),
        .period_in(timer_four_period_in),
        .hit_out(t4_hit)
    );

    pfb_match_det #(
        .TW(TW)
    ) u_t6 (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .count_in(timer_six_count_in),
        .period_in(timer_six_period_in),
        .hit_out(t6_hit)
    );

    // ----------------------------------------
    // Flag banks
    // ----------------------------------------
    pfb_flag_cell #(
        .IMPL_MASK(`PFB_MASK_C)
    ) u_bank_c (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .fl(fc.bank)
    );

    pfb_flag_cell #(
        .IMPL_MASK(`PFB_MASK_D)
    ) u_bank_d (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .fl(fd.bank)
    );

    // ----------------------------------------
    // Event routing, never gated by enables
    // ----------------------------------------
    always_comb begin
        fc.set = 8'h00;
        fc.set[`PFB_POS_CAP4] = cap_unit4_event_in;
        fc.set[`PFB_POS_CAP3] = cap_unit3_event_in;
        fc.set[`PFB_POS_TMR6] = t6_hit;
        fc.set[`PFB_POS_TMR4] = t4_hit;
        fd.set = 8'h00;
        fd.set[`PFB_POS_COLL] = serial2_collision_event_in;
        // Hardware raises done only on completion, so it stays low in flight
        fd.set[`PFB_POS_DONE] = serial2_done_event_in;
    end

    // ----------------------------------------
    // Software writes, committed on the ack edge
    // ----------------------------------------
    assign wr_ack = (st_q.bus == pfb_pkg::pfb_ack) & avs_write_in & avs_byteenable_in[0];
    assign wbyte = avs_writedata_in[7:0];

    always_comb begin
        fc.wr_data = wbyte;
        fd.wr_data = wbyte;
        fc.wr_mask = 8'h00;
        fd.wr_mask = 8'h00;
        if (wr_ack && addr_is(avs_address_in, `PFB_OFS_FLAGS_C)) begin
            fc.wr_mask = `PFB_MASK_C;
        end
        if (wr_ack && addr_is(avs_address_in, `PFB_OFS_FLAGS_D)) begin
            // Only a software write or a reset can drop the collision flag
            fd.wr_mask = `PFB_MASK_D;
        end
    end

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    always_comb begin
        rd_mux = 8'h00;
        case (avs_address_in[3:2])
            2'(`PFB_OFS_FLAGS_C >> 2): begin
                rd_mux = fc.q;
            end
            2'(`PFB_OFS_FLAGS_D >> 2): begin
                rd_mux = fd.q;
            end
            2'(`PFB_OFS_EN_C >> 2): begin
                rd_mux = st_q.en_c;
            end
            2'(`PFB_OFS_EN_D >> 2): begin
                rd_mux = st_q.en_d;
            end
            default: begin
                rd_mux = 8'h00;
            end
        endcase
    end

    assign pend = (fc.q & st_q.en_c) | (fd.q & st_q.en_d);

    // ----------------------------------------
    // Bus handshake, enables and request
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.irq = |pend;
        case (st_q.bus)
            pfb_pkg::pfb_idle: begin
                st_d.waitreq = 1'b1;
                if (avs_read_in || avs_write_in) begin
                    st_d.bus = pfb_pkg::pfb_ack;
                    st_d.waitreq = 1'b0;
                    st_d.rdata = {24'h00_0000, rd_mux};
                end
            end
            pfb_pkg::pfb_ack: begin
                // Back to idle forces one wait cycle between requests
                st_d.bus = pfb_pkg::pfb_idle;
                st_d.waitreq = 1'b1;
                if (wr_ack && addr_is(avs_address_in, `PFB_OFS_EN_C)) begin
                    st_d.en_c = wbyte & `PFB_MASK_C;
                end
                if (wr_ack && addr_is(avs_address_in, `PFB_OFS_EN_D)) begin
                    st_d.en_d = wbyte & `PFB_MASK_D;
                end
            end
            default: begin
                st_d.bus = pfb_pkg::pfb_idle;
                st_d.waitreq = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            st_q.bus <= pfb_pkg::pfb_idle;
            st_q.waitreq <= 1'b1;
            st_q.rdata <= `PFB_RST_RDATA;
            st_q.en_c <= `PFB_RST_EN;
            st_q.en_d <= `PFB_RST_EN;
            st_q.irq <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign avs_readdata_out = st_q.rdata;
    assign avs_waitrequest_out = st_q.waitreq;
    assign peripheral_irq_out = st_q.irq;
    assign flags_c_out = fc.q;
    assign flags_d_out = fd.q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (srst_in);

    logic t4_eq;
    logic wr_d_ack;
    assign t4_eq = (timer_four_count_in == timer_four_period_in);
    assign wr_d_ack = wr_ack & addr_is(avs_address_in, `PFB_OFS_FLAGS_D);

    sequence s_req;
        (avs_read_in || avs_write_in) && (st_q.bus == pfb_pkg::pfb_idle);
    endsequence

    sequence s_answer;
        !avs_waitrequest_out ##1 avs_waitrequest_out;
    endsequence

    sequence s_new_match;
        $rose(t4_eq);
    endsequence

    a_bus_answer: assert property (
        s_req |=> s_answer
    ) else $error("request not answered in one cycle");

    a_cap4_latch: assert property (
        cap_unit4_event_in |=> flags_c_out[5]
    ) else $error("capture 4 flag not latched");

    a_cap3_ungated: assert property (
        (cap_unit3_event_in && !st_q.en_c[4]) |=> flags_c_out[4]
    ) else $error("capture 3 flag gated by enable");

    a_timer_match: assert property (
        s_new_match |-> ##2 flags_c_out[1]
    ) else $error("timer four match flag missing");

    a_unused_zero: assert property (
        ((flags_c_out & ~`PFB_MASK_C) == 8'h00) && ((flags_d_out & ~`PFB_MASK_D) == 8'h00)
        && ((st_q.en_c & ~`PFB_MASK_C) == 8'h00) && ((st_q.en_d & ~`PFB_MASK_D) == 8'h00)
    ) else $error("unimplemented bit set");

    a_reset_clear: assert property (
        @(posedge ref_clk_in) disable iff (1'b0)
        srst_in |=> (flags_c_out == 8'h00) && (flags_d_out == 8'h00) && !peripheral_irq_out
    ) else $error("flags not cleared by reset");

    a_coll_latch: assert property (
        serial2_collision_event_in |=> flags_d_out[1]
    ) else $error("collision flag not latched");

    a_coll_sticky: assert property (
        (flags_d_out[1] && !(wr_d_ack && !avs_writedata_in[1])) |=> flags_d_out[1]
    ) else $error("collision flag dropped without a write");

    a_done_quiet: assert property (
        (!flags_d_out[0] && !serial2_done_event_in && !wr_d_ack) |=> !flags_d_out[0]
    ) else $error("done flag rose without completion");

    a_set_wins: assert property (
        (wr_d_ack && !avs_writedata_in[0] && serial2_done_event_in) |=> flags_d_out[0]
    ) else $error("write clear beat hardware set");

    a_read_flags: assert property (
        (s_req ##0 (avs_read_in && addr_is(avs_address_in, `PFB_OFS_FLAGS_C)))
        |=> avs_readdata_out == {24'h00_0000, $past(flags_c_out)}
    ) else $error("flag bank c read back wrong");

    a_irq_follow: assert property (
        ##1 (peripheral_irq_out == (|$past(pend)))
    ) else $error("request does not follow flags and enables");

    logic t6_eq;
    logic wr_c_ack;
    assign t6_eq = (timer_six_count_in == timer_six_period_in);
    assign wr_c_ack = wr_ack & addr_is(avs_address_in, `PFB_OFS_FLAGS_C);

    // Timer six has a detector of its own, so it is watched on its own
    sequence s_new_match6;
        $rose(t6_eq);
    endsequence

    a_timer6_match: assert property (
        s_new_match6 |-> ##2 flags_c_out[3]
    ) else $error("timer six match flag missing");

    a_done_latch: assert property (
        serial2_done_event_in |=> flags_d_out[0]
    ) else $error("done flag not latched");

    a_ack_single: assert property (
        (st_q.bus == pfb_pkg::pfb_ack) |=> avs_waitrequest_out
    ) else $error("waitrequest low for more than one cycle");

    a_idle_wait: assert property (
        ((st_q.bus == pfb_pkg::pfb_idle) && !avs_read_in && !avs_write_in)
        |=> avs_waitrequest_out
    ) else $error("answer without a request");

    // With no event in the way, a write lands exactly, masked to the bank
    a_write_c_lands: assert property (
        (wr_c_ack && !cap_unit3_event_in && !cap_unit4_event_in && !t4_hit && !t6_hit)
        |=> flags_c_out == ($past(wbyte) & `PFB_MASK_C)
    ) else $error("bank c write did not land");

    a_write_d_lands: assert property (
        (wr_d_ack && !serial2_done_event_in && !serial2_collision_event_in)
        |=> flags_d_out == ($past(wbyte) & `PFB_MASK_D)
    ) else $error("bank d write did not land");

    a_enable_write: assert property (
        (wr_ack && addr_is(avs_address_in, `PFB_OFS_EN_C))
        |=> st_q.en_c == ($past(wbyte) & `PFB_MASK_C)
    ) else $error("bank c enable write wrong");

endmodule

// *** verif/pfb_periph_model.sv ***
`timescale 1ns/1ns
module pfb_periph_model #(
    parameter int TW = 8
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic srst_in,
    // Bench commands: run timers, periods, event requests {coll, done, cap4, cap3}
    input wire logic run_in,
    input wire logic [TW-1:0] t4_period_in,
    input wire logic [TW-1:0] t6_period_in,
    input wire logic [3:0] req_in,
    // Peripheral side of the flag bank
    output logic [3:0] event_out,
    output logic [TW-1:0] t4_count_out,
    output logic [TW-1:0] t6_count_out,
    output logic [TW-1:0] t4_period_out,
    output logic [TW-1:0] t6_period_out
);
    // ----------------------------------------
    // Timers and event sources
    // ----------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            event_out <= 4'h0;
            t4_count_out <= '0;
            t6_count_out <= '0;
            // All ones so an idle timer at count zero never matches
            t4_period_out <= '1;
            t6_period_out <= '1;
        end else begin
            // Events last exactly as long as the bench holds them
            event_out <= req_in;
            t4_period_out <= t4_period_in;
            t6_period_out <= t6_period_in;
            if (run_in) begin
                // Wrap after the period value, so equality lasts one cycle
                t4_count_out <= (t4_count_out == t4_period_out) ? '0 : t4_count_out + 1'b1;
                t6_count_out <= (t6_count_out == t6_period_out) ? '0 : t6_count_out + 1'b1;
            end
        end
    end
endmodule

// *** verif/pfb_flags_bank_tb_top.sv ***
`timescale 1ns/1ns
`include "pfb_defs.svh"
module pfb_flags_bank_tb_top;
    localparam int TW = 8;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] be = 4'hf;
    logic run = 1'b0;
    logic [TW-1:0] p4 = '1;
    logic [TW-1:0] p6 = '1;
    logic [3:0] req = 4'h0;
    logic [31:0] rdata;
    logic wreq;
    logic irq;
    logic [7:0] fc;
    logic [7:0] fd;
    logic [3:0] ev;
    logic [TW-1:0] c4, c6, pp4, pp6;
    int miscompares = 0;
    int checks_done = 0;
    logic [3:0] offs [4] = '{`PFB_OFS_FLAGS_C, `PFB_OFS_FLAGS_D, `PFB_OFS_EN_C, `PFB_OFS_EN_D};
    logic [7:0] bitv [6] = '{8'h20, 8'h10, 8'h08, 8'h02, 8'h02, 8'h01};

    always #10 clk = ~clk;

    pfb_periph_model #(.TW(TW)) model (.ref_clk_in(clk), .srst_in(srst), .run_in(run),
        .t4_period_in(p4), .t6_period_in(p6), .req_in(req), .event_out(ev),
        .t4_count_out(c4), .t6_count_out(c6), .t4_period_out(pp4), .t6_period_out(pp6));

    pfb_flags_bank #(.TW(TW)) dut (.ref_clk_in(clk), .srst_in(srst), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
        .cap_unit3_event_in(ev[0]), .cap_unit4_event_in(ev[1]),
        .timer_four_count_in(c4), .timer_four_period_in(pp4),
        .timer_six_count_in(c6), .timer_six_period_in(pp6),
        .serial2_done_event_in(ev[2]), .serial2_collision_event_in(ev[3]),
        .peripheral_irq_out(irq), .flags_c_out(fc), .flags_d_out(fd));

    // ----------------------------------------
    // Checking and reporting
    // ----------------------------------------
    task wrap_up;
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [7:0] exp_mask(input logic [3:0] a);
        return a[2] ? `PFB_MASK_D : `PFB_MASK_C;
    endfunction

    // ----------------------------------------
    // Bus and event drivers
    // ----------------------------------------
    // Request held until waitrequest is seen low; one idle edge follows
    task bus(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
        int n;
        addr <= a;
        rd <= !w;
        wr <= w;
        wdata <= {24'h00_0000, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 20) begin
            miscompares++;
            $display("wrong value at %0t: bus timeout", $time);
            wrap_up();
        end
        @(posedge clk);
    endtask

    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q[7:0], exp, what);
        chk({q[31:8] !== 24'h00_0000, 7'h00}, 8'h00, "upper read bits");
    endtask

    task fire(input logic [3:0] m);
        req <= m;
        @(posedge clk);
        req <= 4'h0;
        repeat (4) @(posedge clk);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        int k;
        int pmin;
        int pmax;
        logic [7:0] d;
        void'($urandom(13));
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        for (k = 0; k < 4; k++) rd_chk(offs[k], 8'h00, "reset value");
        for (k = 0; k < 12; k++) begin
            d = (k < 4) ? 8'hff : 8'($urandom);
            wr_reg(offs[k % 4], d);
            rd_chk(offs[k % 4], d & exp_mask(offs[k % 4]), "masked bits");
        end
        for (k = 0; k < 4; k++) wr_reg(offs[k], 8'h00);
        be <= 4'he;
        wr_reg(`PFB_OFS_FLAGS_C, 8'hff);
        be <= 4'hf;
        rd_chk(`PFB_OFS_FLAGS_C, 8'h00, "byte lane off");
        // Events latch with every enable clear
        fire(4'hf);
        chk(fc, 8'h30, "capture flags");
        chk(fd, 8'h03, "serial flags");
        chk({7'h00, irq}, 8'h00, "request masked");
        repeat (30) @(posedge clk);
        chk(fd, 8'h03, "flags held");
        rd_chk(`PFB_OFS_FLAGS_D, 8'h03, "bank d read");
        wr_reg(`PFB_OFS_FLAGS_D, 8'h01);
        rd_chk(`PFB_OFS_FLAGS_D, 8'h01, "collision cleared by zero");
        wr_reg(`PFB_OFS_FLAGS_C, 8'h00);
        wr_reg(`PFB_OFS_FLAGS_D, 8'h00);
        rd_chk(`PFB_OFS_FLAGS_C, 8'h00, "stale flags cleared");
        // Transfer in progress: no completion yet
        for (k = 0; k < 8; k++) begin
            @(posedge clk);
            chk(fd, 8'h00, "pending transfer");
        end
        fire(4'h4);
        chk(fd, 8'h01, "transfer complete");
        // Events held across clearing writes: the set wins
        req <= 4'hd;
        wr_reg(`PFB_OFS_FLAGS_C, 8'h00);
        wr_reg(`PFB_OFS_FLAGS_D, 8'h00);
        req <= 4'h0;
        repeat (4) @(posedge clk);
        chk(fc, 8'h10, "set beats clear c");
        chk(fd, 8'h03, "set beats clear d");
        wr_reg(`PFB_OFS_FLAGS_C, 8'h00);
        wr_reg(`PFB_OFS_FLAGS_D, 8'h00);
        // Period match on both timers
        p4 <= TW'($urandom_range(2, 20));
        p6 <= TW'($urandom_range(2, 20));
        repeat (2) @(posedge clk);
        pmin = (p4 < p6) ? int'(p4) : int'(p6);
        pmax = (p4 < p6) ? int'(p6) : int'(p4);
        run <= 1'b1;
        repeat (pmin) @(posedge clk);
        chk(fc, 8'h00, "no match yet");
        repeat (pmax - pmin + 4) @(posedge clk);
        run <= 1'b0;
        chk(fc, 8'h0a, "timer match");
        // Let a last match from the running timers land before the clear
        repeat (3) @(posedge clk);
        wr_reg(`PFB_OFS_FLAGS_C, 8'h00);
        repeat (4) @(posedge clk);
        chk(fc, 8'h00, "held count no reset");
        // Request per flag and enable pair
        for (k = 0; k < 6; k++) begin
            wr_reg(offs[(k < 4) ? 2 : 3], bitv[k]);
            wr_reg(offs[(k < 4) ? 0 : 1], exp_mask(offs[(k < 4) ? 0 : 1]) & ~bitv[k]);
            repeat (2) @(posedge clk);
            chk({7'h00, irq}, 8'h00, "other flags");
            wr_reg(offs[(k < 4) ? 0 : 1], bitv[k]);
            repeat (2) @(posedge clk);
            chk({7'h00, irq}, 8'h01, "request raised");
            wr_reg(offs[(k < 4) ? 2 : 3], 8'h00);
            repeat (2) @(posedge clk);
            chk({7'h00, irq}, 8'h00, "request dropped");
            wr_reg(offs[(k < 4) ? 0 : 1], 8'h00);
        end
        // Reset in mid-run
        fire(4'hf);
        wr_reg(`PFB_OFS_EN_D, 8'hff);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        for (k = 0; k < 4; k++) rd_chk(offs[k], 8'h00, "second reset");
        chk({7'h00, irq}, 8'h00, "request after reset");
        wrap_up();
    end
endmodule
